// >>> verilog/spim_pkg.sv
// constants, types and register map of the byte-serial master
// assumes a 100 MHz system clock and one AHB-Lite slave port
package spim_pkg;

   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned PIN_W         = 5;
   localparam int unsigned NUM_PINS      = 32;

   localparam logic [11:0] OFF_EVENT     = 12'h108;
   localparam logic [11:0] OFF_IRQ_SET   = 12'h304;
   localparam logic [11:0] OFF_IRQ_CLR   = 12'h308;
   localparam logic [11:0] OFF_ENABLE    = 12'h500;
   localparam logic [11:0] OFF_PSEL_SCK  = 12'h508;
   localparam logic [11:0] OFF_PSEL_MOSI = 12'h50C;
   localparam logic [11:0] OFF_PSEL_MISO = 12'h510;
   localparam logic [11:0] OFF_RXD       = 12'h518;
   localparam logic [11:0] OFF_TXD       = 12'h51C;

   localparam logic [31:0] RST_PSEL      = 32'hFFFFFFFF;
   localparam logic [31:0] RST_ZERO      = 32'h00000000;
   localparam logic [3:0]  ENABLE_ON     = 4'h1;
   localparam int unsigned READY_BIT     = 0;
   localparam int unsigned CONNECT_BIT   = 31;

   // serial clock: 250 kbps after reset
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SCK_PERIOD_NS = 4000;
   localparam int unsigned SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   typedef struct packed {
      logic        disconnect;
      logic [25:0] unused;
      logic [4:0]  pin;
   } spim_psel_type;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
   } spim_ahb_req_type;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'b00,
      ENG_LOW  = 2'b01,
      ENG_HIGH = 2'b10
   } spim_eng_state_type;

endpackage : spim_pkg

// >>> verilog/spim_shifter.sv
// one-byte shift engine, clock low at rest, msb first
// assumes miso_s is already synchronised to hclk
`timescale 1ns/1ps
module spim_shifter #(
   parameter int unsigned HALF_CYC = spim_pkg::SCK_HALF_CYC
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       start,
   input  wire logic [7:0] tx_byte,
   input  wire logic       miso_s,
   output logic            sck,
   output logic            mosi,
   output logic            busy,
   output logic            done,
   output logic [7:0]      rx_byte
);
   spim_pkg::spim_eng_state_type state_q;
   logic [15:0] cnt_q;
   logic [2:0]  bit_q;
   logic [7:0]  tx_q;
   logic [7:0]  rx_q;
   logic        done_q;
   wire         tick = (cnt_q == 16'(HALF_CYC - 1));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cnt_q <= 16'h0000;
      else if (state_q == spim_pkg::ENG_IDLE || tick)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= spim_pkg::ENG_IDLE;
         bit_q   <= 3'h0;
         tx_q    <= 8'h00;
         rx_q    <= 8'h00;
         done_q  <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         unique case (state_q)
            spim_pkg::ENG_IDLE:
               if (start)
               begin
                  tx_q    <= tx_byte;
                  bit_q   <= 3'h0;
                  state_q <= spim_pkg::ENG_LOW;
               end
            spim_pkg::ENG_LOW:
               if (tick)
               begin
                  rx_q    <= {rx_q[6:0], miso_s};
                  state_q <= spim_pkg::ENG_HIGH;
               end
            spim_pkg::ENG_HIGH:
               if (tick)
               begin
                  tx_q  <= {tx_q[6:0], 1'b0};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7)
                  begin
                     done_q  <= 1'b1;
                     state_q <= spim_pkg::ENG_IDLE;
                  end
                  else
                     state_q <= spim_pkg::ENG_LOW;
               end
            default:
               state_q <= spim_pkg::ENG_IDLE;
         endcase
      end
   end

   assign sck     = (state_q == spim_pkg::ENG_HIGH);
   assign mosi    = tx_q[7];
   assign busy    = (state_q != spim_pkg::ENG_IDLE);
   assign done    = done_q;
   assign rx_byte = rx_q;

   byte_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(busy) |-> busy [*8])
      else $error("shifter left a byte early");
endmodule : spim_shifter

// >>> verilog/spim_master.sv
// register view and pin muxing of the byte-serial master
// assumes one AHB-Lite master; gpio_in comes from pads, unsynchronised
`timescale 1ns/1ps
// Summary of operation
// - set register write-one enables done interrupt
// - out pin select: pin field, bit31 disconnects
// - in pin select alike, disconnected after reset
// - receive register read-only, backed by second byte
// - done event whenever receive register refills
// - transfer on write, in order, stop empty
// - backing byte moves up after receive read
module spim_master #(
   parameter int unsigned HALF_CYC = spim_pkg::SCK_HALF_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [31:0] gpio_in,
   output logic [31:0]      gpio_out,
   output logic [31:0]      gpio_oe_n,
   output logic             irq
);
   spim_pkg::spim_ahb_req_type req_q;
   logic        wr_pend_q;
   logic        rd_pend_q;
   logic [31:0] hrdata_q;
   logic        event_q;
   logic        irq_en_q;
   logic [3:0]  enable_q;
   spim_pkg::spim_psel_type psel_sck_q;
   spim_pkg::spim_psel_type psel_mosi_q;
   spim_pkg::spim_psel_type psel_miso_q;
   logic [7:0]  txd_q;
   logic        tx_pend_q;
   logic [7:0]  rxd_q;
   logic        rxd_v_q;
   logic [7:0]  rxb_q;
   logic        rxb_v_q;
   logic [31:0] in_s1_q;
   logic [31:0] in_s2_q;
   logic [31:0] gpio_out_q;
   logic [31:0] gpio_oe_n_q;
   logic        eng_sck;
   logic        eng_mosi;
   logic        eng_busy;
   logic        eng_done;
   logic [7:0]  eng_rx;

   // bus decode
   wire addr_phase = hsel && htrans[1] && hready;
   wire wr_en      = wr_pend_q;
   wire rd_en      = rd_pend_q;
   wire hit_event  = (req_q.addr == spim_pkg::OFF_EVENT);
   wire hit_set    = (req_q.addr == spim_pkg::OFF_IRQ_SET);
   wire hit_clr    = (req_q.addr == spim_pkg::OFF_IRQ_CLR);
   wire hit_enable = (req_q.addr == spim_pkg::OFF_ENABLE);
   wire hit_sck    = (req_q.addr == spim_pkg::OFF_PSEL_SCK);
   wire hit_mosi   = (req_q.addr == spim_pkg::OFF_PSEL_MOSI);
   wire hit_miso   = (req_q.addr == spim_pkg::OFF_PSEL_MISO);
   wire hit_rxd    = (req_q.addr == spim_pkg::OFF_RXD);
   wire hit_txd    = (req_q.addr == spim_pkg::OFF_TXD);
   wire rd_rxd     = rd_en && hit_rxd;
   wire rd_event   = rd_en && hit_event;
   wire wr_txd     = wr_en && hit_txd;
   wire enabled    = (enable_q == spim_pkg::ENABLE_ON);

   // engine start: only while the backing byte is empty, even in the cycle a finishing answer fills it
   wire eng_start  = enabled && tx_pend_q && !eng_busy && !rxb_v_q;

   // receive path events
   wire rx_move    = rd_rxd && rxb_v_q;
   wire rx_land    = eng_done && (!rxd_v_q || (rd_rxd && !rxb_v_q));
   wire fire_event = rx_move || rx_land;

   wire [31:0] rd_mux =
      hit_event  ? {31'h0, event_q} :
      (hit_set || hit_clr) ? {31'h0, irq_en_q} :
      hit_enable ? {28'h0, enable_q} :
      hit_sck    ? psel_sck_q :
      hit_mosi   ? psel_mosi_q :
      hit_miso   ? psel_miso_q :
      hit_rxd    ? {24'h0, rxd_q} :
      hit_txd    ? {24'h0, txd_q} : 32'h00000000;

   // reads take one wait state so that side effects and data share one edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         req_q     <= '0;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hrdata_q  <= spim_pkg::RST_ZERO;
      end
      else
      begin
         wr_pend_q <= addr_phase && hwrite;
         rd_pend_q <= addr_phase && !hwrite;
         if (addr_phase)
            req_q <= '{write: hwrite, addr: haddr[spim_pkg::ADDR_W-1:0]};
         if (rd_en)
            hrdata_q <= rd_mux;
      end
   end

   assign hreadyout = !rd_pend_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // configuration registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_en_q    <= 1'b0;
         enable_q    <= 4'h0;
         psel_sck_q  <= spim_pkg::RST_PSEL;
         psel_mosi_q <= spim_pkg::RST_PSEL;
         psel_miso_q <= spim_pkg::RST_PSEL;
      end
      else if (wr_en)
      begin
         if (hit_set && hwdata[spim_pkg::READY_BIT])
            irq_en_q <= 1'b1;
         else if (hit_clr && hwdata[spim_pkg::READY_BIT])
            irq_en_q <= 1'b0;
         if (hit_enable)
            enable_q <= hwdata[3:0];
         if (hit_sck)
            psel_sck_q <= hwdata;
         if (hit_mosi)
            psel_mosi_q <= hwdata;
         if (hit_miso)
            psel_miso_q <= hwdata;
      end
   end

   // sticky event: a new byte wins over the clearing read
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         event_q <= 1'b0;
      else if (fire_event)
         event_q <= 1'b1;
      else if (rd_event)
         event_q <= 1'b0;
   end

   assign irq = event_q && irq_en_q;

   // transmit buffer feeding the engine, which holds the second byte
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         txd_q     <= 8'h00;
         tx_pend_q <= 1'b0;
      end
      else
      begin
         if (wr_txd)
            txd_q <= hwdata[7:0];
         if (wr_txd)
            tx_pend_q <= 1'b1;
         else if (eng_start)
            tx_pend_q <= 1'b0;
      end
   end

   // receive register and its backing byte
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rxd_q   <= 8'h00;
         rxd_v_q <= 1'b0;
         rxb_q   <= 8'h00;
         rxb_v_q <= 1'b0;
      end
      else if (rx_move)
      begin
         rxd_q   <= rxb_q;
         rxd_v_q <= 1'b1;
         rxb_q   <= eng_done ? eng_rx : rxb_q;
         rxb_v_q <= eng_done;
      end
      else if (rx_land)
      begin
         rxd_q   <= eng_rx;
         rxd_v_q <= 1'b1;
      end
      else if (eng_done)
      begin
         rxb_q   <= eng_rx;
         rxb_v_q <= 1'b1;
      end
      else if (rd_rxd)
         rxd_v_q <= 1'b0;
   end

   // pad inputs pass two flops before the pin mux reads them
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_s1_q <= 32'h00000000;
         in_s2_q <= 32'h00000000;
      end
      else
      begin
         in_s1_q <= gpio_in;
         in_s2_q <= in_s1_q;
      end
   end

   wire miso_s = enabled && !psel_miso_q.disconnect && in_s2_q[psel_miso_q.pin];

   // pin drive: output enable is active low; an unconnected signal drives nothing
   genvar gi;
   generate
      for (gi = 0; gi < spim_pkg::NUM_PINS; gi++)
      begin : g_pin
         wire sck_here  = enabled && !psel_sck_q.disconnect && (psel_sck_q.pin == gi);
         wire mosi_here = enabled && !psel_mosi_q.disconnect && (psel_mosi_q.pin == gi);
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               gpio_out_q[gi]  <= 1'b0;
               gpio_oe_n_q[gi] <= 1'b1;
            end
            else
            begin
               gpio_out_q[gi]  <= sck_here ? eng_sck : (mosi_here && eng_mosi);
               gpio_oe_n_q[gi] <= !(sck_here || mosi_here);
            end
         end
      end
   endgenerate

   assign gpio_out  = gpio_out_q;
   assign gpio_oe_n = gpio_oe_n_q;

   spim_shifter #(
      .HALF_CYC (HALF_CYC)
   ) u_shifter (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (eng_start),
      .tx_byte (txd_q),
      .miso_s  (miso_s),
      .sck     (eng_sck),
      .mosi    (eng_mosi),
      .busy    (eng_busy),
      .done    (eng_done),
      .rx_byte (eng_rx)
   );

   // checks
   irq_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_en && hit_set && hwdata[0]) |=> irq_en_q)
      else $error("enable set did not take");
   irq_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_en && hit_clr && hwdata[0] && !hit_set) |=> !irq_en_q)
      else $error("enable clear did not take");
   enable_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_en && (hit_set || hit_clr)) |=> (hrdata == {31'h0, $past(irq_en_q)}))
      else $error("enable read-back wrong");
   mosi_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (psel_mosi_q.disconnect && psel_sck_q.disconnect) |=> (gpio_oe_n == 32'hFFFFFFFF))
      else $error("disconnected pins driven");
   miso_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      psel_miso_q.disconnect |-> !miso_s)
      else $error("disconnected input sampled");
   rx_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_en && hit_rxd && !eng_done && !rx_move) |=> $stable(rxd_q))
      else $error("receive register written");
   tx_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (tx_pend_q && enabled && !rxb_v_q && !eng_busy && !wr_txd) |=> eng_busy && !tx_pend_q)
      else $error("queued byte not started");
   event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rx_land || rx_move) |=> event_q && rxd_v_q)
      else $error("byte landed without event");
   move_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_rxd && rxb_v_q) |=> (rxd_q == $past(rxb_q)))
      else $error("backing byte not moved");
   tx_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_txd && eng_busy) |=> tx_pend_q && (txd_q == $past(hwdata[7:0])))
      else $error("second byte not queued");
   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   // the engine never starts with the backing byte full, but a byte started in the cycle it fills overwrites it unless the receive register is read first
   keep_rx_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rxb_v_q && !rd_rxd) |=> rxb_v_q && $stable(rxb_q))
      else $error("backing byte lost");
   land_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_land |=> (rxd_q == $past(eng_rx)))
      else $error("received byte not landed");
   ev_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_event && !fire_event) |=> !event_q)
      else $error("event not cleared by read");
   tx_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (eng_done && !tx_pend_q) |=> !eng_busy)
      else $error("engine ran on with nothing queued");

   // pins are registered, so each pin check looks one edge after the select it used
   pins_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !enabled |=> (gpio_oe_n == 32'hFFFFFFFF))
      else $error("pin driven while disabled");
   sck_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (enabled && !psel_sck_q.disconnect) |=>
         (gpio_out[$past(psel_sck_q.pin)] == $past(eng_sck)) && !gpio_oe_n[$past(psel_sck_q.pin)])
      else $error("clock pin not driven");
   mosi_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (enabled && !psel_mosi_q.disconnect && (psel_sck_q.disconnect || psel_sck_q.pin != psel_mosi_q.pin)) |=>
         (gpio_out[$past(psel_mosi_q.pin)] == $past(eng_mosi)) && !gpio_oe_n[$past(psel_mosi_q.pin)])
      else $error("data pin not driven");

   two_bytes_c: cover property (@(posedge hclk) disable iff (!hresetn)
      eng_busy && tx_pend_q);
   backing_c: cover property (@(posedge hclk) disable iff (!hresetn)
      rx_move);
   irq_c: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(irq));
   stall_c: cover property (@(posedge hclk) disable iff (!hresetn)
      tx_pend_q && rxb_v_q && !eng_busy);
   miso_off_c: cover property (@(posedge hclk) disable iff (!hresetn)
      eng_done && psel_miso_q.disconnect);
endmodule : spim_master

// >>> verif/spim_slave_model.sv
// behavioural serial slave, mode 0, msb first, answers a fixed list of bytes
// assumes sck idles low and is already a clean pad level (no chip select)
`timescale 1ns/1ps
module spim_slave_model #(
   parameter logic [15:0] REPLIES = 16'hC35A
) (
   input  wire logic    sck,
   input  wire logic    mosi,
   output logic         miso,
   output logic [31:0]  got_log,
   output int unsigned  got_cnt
);
   logic [7:0]  tx_q = REPLIES[15:8];
   logic [7:0]  rx_q = 8'h00;
   int unsigned bits = 0;
   assign miso = tx_q[7];
   initial got_log = 32'h00000000;
   initial got_cnt = 0;
   // sample on the rising edge, log each whole byte
   always @(posedge sck)
   begin
      rx_q = {rx_q[6:0], mosi};
      bits = (bits + 1) % 8;
      if (bits == 0)
      begin
         got_log = {got_log[23:0], rx_q};
         got_cnt = got_cnt + 1;
      end
   end
   // shift on the falling edge; after the list is used up the line is held high
   always @(negedge sck)
   begin
      if (bits != 0)
         tx_q = tx_q << 1;
      else
         tx_q = (got_cnt == 0) ? REPLIES[15:8] : (got_cnt == 1) ? REPLIES[7:0] : 8'hFF;
   end
endmodule : spim_slave_model

// >>> verif/spi_master_register_interface_test.sv
// register-level bench of the byte-serial master over AHB-Lite
// assumes pads with pull-down; sck on pin 3, mosi on pin 7, miso on pin 12
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
   begin \
      num_checks++; \
      if ((gt) !== (ex)) \
      begin \
         miscompares++; \
         $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module spi_master_register_interface_test;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h00000000;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata, gpio_out, gpio_oe_n, pads, got_log, rdv;
   logic        hreadyout, hresp, irq, miso;
   int unsigned got_cnt;
   int          miscompares = 0;
   int          num_checks = 0;
   logic [11:0] ra [9] = '{spim_pkg::OFF_IRQ_SET, spim_pkg::OFF_IRQ_CLR, spim_pkg::OFF_ENABLE,
      spim_pkg::OFF_PSEL_SCK, spim_pkg::OFF_PSEL_MOSI, spim_pkg::OFF_PSEL_MISO, spim_pkg::OFF_RXD,
      spim_pkg::OFF_TXD, spim_pkg::OFF_EVENT};
   logic [31:0] rx [9] = '{32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0};

   always #5 hclk = ~hclk;
   // released pads fall to the pull-down, so stale values never linger
   assign pads = (gpio_out & ~gpio_oe_n) | (gpio_oe_n & ({31'h0, miso} << 12));

   spim_master #(.HALF_CYC(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_in(pads), .gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .irq(irq));
   spim_slave_model #(.REPLIES(16'hC35A)) peer_u (.sck(pads[3]), .mosi(pads[7]), .miso(miso),
      .got_log(got_log), .got_cnt(got_cnt));

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task hang;
      miscompares++;
      $display("[FAIL] wait expected done seen timeout");
      finish_test();
   endtask : hang

   // one single transfer; both wait loops share one bound of 20 cycles, after which the bench calls hang
   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {20'h0, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         @(posedge hclk);
         n++;
      end
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= 20)
         hang();
      rd = hrdata;
   endtask : ahb

   task wr(input logic [11:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, rdv);
   endtask : wr

   task rd(input string nm, input logic [11:0] a, input logic [31:0] ex);
      logic [31:0] v;
      ahb(1'b0, a, 32'h0, v);
      `CHK(nm, ex, v)
   endtask : rd

   task wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 400)
      begin
         @(posedge hclk);
         n++;
      end
      if (irq !== lvl)
         hang();
   endtask : wait_irq

   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      `CHK("oe_n", 32'hFFFFFFFF, gpio_oe_n)
      `CHK("hresp", 1'b0, hresp)
      for (int i = 0; i < 9; i++) rd("reset", ra[i], rx[i]);
      $display("reset values done");
      wr(spim_pkg::OFF_IRQ_SET, 32'h1);
      wr(spim_pkg::OFF_IRQ_SET, 32'h0);
      rd("enable_set", spim_pkg::OFF_IRQ_SET, 32'h1);
      wr(spim_pkg::OFF_IRQ_CLR, 32'h0);
      rd("enable_clr", spim_pkg::OFF_IRQ_CLR, 32'h1);
      wr(spim_pkg::OFF_IRQ_CLR, 32'h1);
      rd("enable_set", spim_pkg::OFF_IRQ_SET, 32'h0);
      wr(12'h400, 32'hFFFFFFFF);
      rd("unmapped", 12'h400, 32'h0);
      $display("enable registers done");
      // the engine runs whether or not the clock pin is connected; the peer only sees it through pin 3
      wr(spim_pkg::OFF_PSEL_SCK, 32'h3);
      wr(spim_pkg::OFF_PSEL_MOSI, 32'h7);
      wr(spim_pkg::OFF_PSEL_MISO, 32'hC);
      rd("psel_out", spim_pkg::OFF_PSEL_MOSI, 32'h7);
      wr(spim_pkg::OFF_IRQ_SET, 32'h1);
      wr(spim_pkg::OFF_ENABLE, 32'h1);
      repeat (2) @(posedge hclk);
      `CHK("oe_n", 32'hFFFFFF77, gpio_oe_n)
      wr(spim_pkg::OFF_TXD, 32'hFFFFFF96);
      wr(spim_pkg::OFF_TXD, 32'h00000069);
      rd("txd", spim_pkg::OFF_TXD, 32'h69);
      wait_irq(1'b1);
      `CHK("sent0", 8'h96, got_log[7:0])
      wr(spim_pkg::OFF_IRQ_CLR, 32'h1);
      @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      wr(spim_pkg::OFF_IRQ_SET, 32'h1);
      @(posedge hclk);
      `CHK("irq", 1'b1, irq)
      for (int n = 0; n < 400 && got_cnt < 2; n++) @(posedge hclk);
      if (got_cnt < 2)
         hang();
      // the done pulse trails the last high phase by under one half period plus pin lag
      repeat (16) @(posedge hclk);
      `CHK("sent1", 8'h69, got_log[7:0])
      rd("event", spim_pkg::OFF_EVENT, 32'h1);
      @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      wr(spim_pkg::OFF_RXD, 32'h77);
      rd("rxd", spim_pkg::OFF_RXD, 32'hC3);
      wait_irq(1'b1);
      rd("event", spim_pkg::OFF_EVENT, 32'h1);
      rd("rxd", spim_pkg::OFF_RXD, 32'h5A);
      repeat (300) @(posedge hclk);
      `CHK("count", 2, got_cnt)
      `CHK("sck", 1'b0, pads[3])
      rd("event", spim_pkg::OFF_EVENT, 32'h0);
      $display("transfer done");
      wr(spim_pkg::OFF_ENABLE, 32'h0);
      repeat (2) @(posedge hclk);
      `CHK("oe_n", 32'hFFFFFFFF, gpio_oe_n)
      wr(spim_pkg::OFF_PSEL_MISO, 32'h8000000C);
      wr(spim_pkg::OFF_ENABLE, 32'h1);
      wr(spim_pkg::OFF_TXD, 32'h000000A5);
      wait_irq(1'b1);
      `CHK("sent2", 8'hA5, got_log[7:0])
      rd("rxd_off", spim_pkg::OFF_RXD, 32'h0);
      `CHK("count", 3, got_cnt)
      $display("disconnected input done");
      finish_test();
   end
endmodule : spi_master_register_interface_test
